// File: pkg/epi_params.svh
`ifndef EPI_PARAMS_SVH
`define EPI_PARAMS_SVH
// ==========================================================
// register offsets
`define EPI_OFS_GRP_FLAGS 8'h1B
`define EPI_OFS_REQ_FLAGS 8'h1C
`define EPI_OFS_REQ_EN 8'h1D
`define EPI_OFS_GRP_EN 8'h68
`define EPI_OFS_SENSE 8'h69
`define EPI_OFS_MASK0 8'h6B
`define EPI_OFS_MASK1 8'h6C
`define EPI_OFS_MASK2 8'h6D
// ==========================================================
// reset values
`define EPI_RST_REG 8'h00
`define EPI_RST_STATE '0
// ==========================================================
// field positions and widths
`define EPI_SENSE_W 4
`define EPI_SENSE_FLD 2
`define EPI_REQ_W 2
`define EPI_GRP_W 3
`define EPI_VEC_W 5
`define EPI_VEC_GRP_LSB 2
`define EPI_MASK_W 8
`define EPI_MASK1_W 7
`define EPI_CHG_W 24
`define EPI_GRP1_LSB 8
`define EPI_GRP1_MSB 14
`define EPI_GRP2_LSB 16
// ==========================================================
// timing counts
`define EPI_PRIME_DONE 2'h3
`endif

// File: pkg/epi_pkg.sv
`include "epi_params.svh"
package epi_pkg;

  // ==========================================================
  // sense control encoding
  typedef enum logic [1:0] {
    EPI_LOW_LEVEL = 2'h0,
    EPI_ANY_CHANGE = 2'h1,
    EPI_FALL_EDGE = 2'h2,
    EPI_RISE_EDGE = 2'h3
  } epi_sense_e;

  // ==========================================================
  // register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } epi_bus_s;

  // ==========================================================
  // whole block state
  typedef struct packed {
    logic [1:0] req_meta;
    logic [1:0] req_sync;
    logic [1:0] req_prev;
    logic [23:0] chg_meta;
    logic [23:0] chg_sync;
    logic [23:0] chg_prev;
    logic [1:0] prime;
    logic [3:0] sense;
    logic [1:0] req_en;
    logic [1:0] req_flag;
    logic [2:0] grp_en;
    logic [2:0] grp_flag;
    logic [7:0] mask0;
    logic [6:0] mask1;
    logic [7:0] mask2;
    logic [7:0] rdata;
    logic [4:0] vec_req;
    logic irq;
    logic wake;
  } epi_state_s;

endpackage : epi_pkg

// File: logic/epi_top.sv
// Function
// (R1) pins interrupt even when driven as outputs
// (R2) three change groups 23..16, 14..8, 7..0
// (R3) per-group masks select contributing pins
// (R4) pin change detection independent of I/O clock
// (R5) sense fields: low, any, falling, rising
// (R6) level mode requests while pin held low
// (R7) edges recognised only while I/O clock runs
// (R8) low level detected without the I/O clock
// (R9) level removed early gives no interrupt
// (R10) sample pin, then detect edges
// (R11) source holds low level until instruction ends
// (R12) request needs enable bit and global flag
// (R13) each request pin has own vector
// (R14) edge sets flag; vector or one clears
// (R15) flag held clear in level mode
// (R16) unused bits read zero, writes ignored
// (R17) group needs enable bit and global flag
// (R18) change sets group flag; vector or one clears
// (R19) two-stage synchroniser then compare with previous
`include "epi_params.svh"
module epi_top
  import epi_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // register port
  input wire epi_bus_s bus_i,
  output logic [7:0] rdata_o,
  // external pins
  input wire logic request_pin_0_i,
  input wire logic request_pin_1_i,
  input wire logic [23:0] change_inputs_i,
  // cpu side
  input wire logic global_irq_en_i,
  input wire logic io_clk_run_i,
  input wire logic [4:0] vector_taken_i,
  output logic [4:0] vec_req_o,
  output logic irq_o,
  output logic wake_o
);

  // ==========================================================
  // state
  epi_state_s st;
  epi_state_s next_st;
  logic primed;
  logic [1:0] rise;
  logic [1:0] fall;
  logic [1:0] edge_hit;
  logic [1:0] level_low;
  logic [1:0] w1c_req;
  logic [2:0] w1c_grp;
  logic [2:0] grp_hit;
  logic [23:0] toggle;
  epi_sense_e mode [2];

  // ==========================================================
  // next state
  always_comb
  begin
    next_st = st;
    primed = (st.prime == `EPI_PRIME_DONE);
    w1c_req = '0;
    w1c_grp = '0;
    rise = '0;
    fall = '0;
    edge_hit = '0;
    level_low = '0;
    mode[0] = EPI_LOW_LEVEL;
    mode[1] = EPI_LOW_LEVEL;
    // pins are read whatever their port direction
    next_st.req_meta = {request_pin_1_i, request_pin_0_i}; // (R1)
    next_st.chg_meta = change_inputs_i; // (R1)
    next_st.req_sync = st.req_meta; // (R19)
    next_st.req_prev = st.req_sync; // (R10)
    next_st.chg_sync = st.chg_meta; // (R19)
    next_st.chg_prev = st.chg_sync; // (R4)
    if (!primed)
    begin
      next_st.prime = 2'(st.prime + 2'h1);
    end
    // request pin sense decode
    for (int i = 0; i < `EPI_REQ_W; i++)
    begin
      mode[i] = epi_sense_e'(st.sense[i*`EPI_SENSE_FLD +: `EPI_SENSE_FLD]); // (R5)
      rise[i] = st.req_sync[i] & ~st.req_prev[i]; // (R19)
      fall[i] = ~st.req_sync[i] & st.req_prev[i]; // (R19)
      case (mode[i])
        EPI_LOW_LEVEL:
        begin
          edge_hit[i] = 1'b0;
          level_low[i] = primed & ~st.req_sync[i]; // (R6) (R8)
        end
        EPI_ANY_CHANGE:
        begin
          edge_hit[i] = rise[i] | fall[i]; // (R5)
        end
        EPI_FALL_EDGE:
        begin
          edge_hit[i] = fall[i]; // (R5)
        end
        EPI_RISE_EDGE:
        begin
          edge_hit[i] = rise[i]; // (R5)
        end
        default:
        begin
          edge_hit[i] = 1'b0;
        end
      endcase
      edge_hit[i] = edge_hit[i] & primed & io_clk_run_i; // (R7) (R10)
    end
    // pin change groups
    toggle = (st.chg_sync ^ st.chg_prev) & {`EPI_CHG_W{primed}}; // (R4)
    grp_hit[0] = |(toggle[`EPI_MASK_W-1:0] & st.mask0); // (R2) (R3)
    grp_hit[1] = |(toggle[`EPI_GRP1_MSB:`EPI_GRP1_LSB] & st.mask1); // (R2) (R3)
    grp_hit[2] = |(toggle[`EPI_CHG_W-1:`EPI_GRP2_LSB] & st.mask2); // (R2) (R3)
    // register writes, reserved bits dropped
    if (bus_i.wr)
    begin
      case (bus_i.addr)
        `EPI_OFS_SENSE:
        begin
          next_st.sense = bus_i.wdata[`EPI_SENSE_W-1:0]; // (R16)
        end
        `EPI_OFS_REQ_EN:
        begin
          next_st.req_en = bus_i.wdata[`EPI_REQ_W-1:0]; // (R16)
        end
        `EPI_OFS_GRP_EN:
        begin
          next_st.grp_en = bus_i.wdata[`EPI_GRP_W-1:0]; // (R16)
        end
        `EPI_OFS_MASK0:
        begin
          next_st.mask0 = bus_i.wdata;
        end
        `EPI_OFS_MASK1:
        begin
          next_st.mask1 = bus_i.wdata[`EPI_MASK1_W-1:0]; // (R16)
        end
        `EPI_OFS_MASK2:
        begin
          next_st.mask2 = bus_i.wdata;
        end
        `EPI_OFS_REQ_FLAGS:
        begin
          w1c_req = bus_i.wdata[`EPI_REQ_W-1:0]; // (R14)
        end
        `EPI_OFS_GRP_FLAGS:
        begin
          w1c_grp = bus_i.wdata[`EPI_GRP_W-1:0]; // (R18)
        end
        default:
        begin
          w1c_req = '0;
        end
      endcase
    end
    // sticky flags, set wins over clear
    next_st.req_flag = (st.req_flag & ~w1c_req & ~vector_taken_i[`EPI_REQ_W-1:0])
      | edge_hit; // (R14)
    for (int i = 0; i < `EPI_REQ_W; i++)
    begin
      if (mode[i] == EPI_LOW_LEVEL)
      begin
        next_st.req_flag[i] = 1'b0; // (R15)
      end
    end
    next_st.grp_flag = (st.grp_flag & ~w1c_grp
      & ~vector_taken_i[`EPI_VEC_W-1:`EPI_VEC_GRP_LSB]) | grp_hit; // (R18)
    // register reads, data one cycle later
    next_st.rdata = `EPI_RST_REG;
    if (bus_i.rd)
    begin
      case (bus_i.addr)
        `EPI_OFS_SENSE:
        begin
          next_st.rdata = {4'h0, st.sense}; // (R16)
        end
        `EPI_OFS_REQ_EN:
        begin
          next_st.rdata = {6'h00, st.req_en}; // (R16)
        end
        `EPI_OFS_GRP_EN:
        begin
          next_st.rdata = {5'h00, st.grp_en}; // (R16)
        end
        `EPI_OFS_MASK0:
        begin
          next_st.rdata = st.mask0;
        end
        `EPI_OFS_MASK1:
        begin
          next_st.rdata = {1'h0, st.mask1}; // (R16)
        end
        `EPI_OFS_MASK2:
        begin
          next_st.rdata = st.mask2;
        end
        `EPI_OFS_REQ_FLAGS:
        begin
          next_st.rdata = {6'h00, st.req_flag}; // (R16)
        end
        `EPI_OFS_GRP_FLAGS:
        begin
          next_st.rdata = {5'h00, st.grp_flag}; // (R16)
        end
        default:
        begin
          next_st.rdata = `EPI_RST_REG;
        end
      endcase
    end
    // one dedicated request line per vector
    next_st.vec_req[`EPI_REQ_W-1:0] = {`EPI_REQ_W{global_irq_en_i}} & st.req_en
      & (level_low | next_st.req_flag); // (R12) (R13) (R6) (R9)
    next_st.vec_req[`EPI_VEC_W-1:`EPI_VEC_GRP_LSB] = {`EPI_GRP_W{global_irq_en_i}}
      & st.grp_en & next_st.grp_flag; // (R17) (R2)
    next_st.irq = |next_st.vec_req;
    // wake does not depend on the I/O clock
    next_st.wake = |(st.req_en & level_low) | |(st.grp_en & next_st.grp_flag); // (R4) (R8)
  end

  // ==========================================================
  // state register
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      st <= `EPI_RST_STATE;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ==========================================================
  // outputs
  assign rdata_o = st.rdata;
  assign vec_req_o = st.vec_req;
  assign irq_o = st.irq;
  assign wake_o = st.wake;

  // ==========================================================
  // checks
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  a_level_request: assert property ( // (R6)
    (global_irq_en_i && st.req_en[0] && st.sense[1:0] == 2'h0 && primed
      && !st.req_sync[0]) |=> vec_req_o[0])
    else $error("level request not raised");

  a_level_flag_clear: assert property ( // (R15)
    (st.sense[3:2] == 2'h0) |=> !st.req_flag[1])
    else $error("flag set in level mode");

  a_fall_sets_flag: assert property ( // (R14)
    (st.sense[1:0] == 2'h2 && io_clk_run_i && primed
      && st.req_prev[0] && !st.req_sync[0]) |=> st.req_flag[0])
    else $error("falling edge lost");

  a_edge_needs_clock: assert property ( // (R7)
    $rose(st.req_flag[1]) |-> $past(io_clk_run_i))
    else $error("edge seen without io clock");

  a_set_wins_clear: assert property ( // (R18)
    (grp_hit[1] && bus_i.wr && bus_i.addr == `EPI_OFS_GRP_FLAGS && bus_i.wdata[1])
      |=> st.grp_flag[1])
    else $error("group event lost on clear");

  a_vector_clears: assert property ( // (R14)
    (vector_taken_i[1] && !edge_hit[1]) |=> !st.req_flag[1])
    else $error("vector entry did not clear flag");

  a_group_gate: assert property ( // (R17)
    vec_req_o[4] |-> $past(global_irq_en_i && st.grp_en[2]))
    else $error("group request without enables");

  a_group_toggle: assert property ( // (R3)
    (st.mask2[5] && primed && (st.chg_sync[21] != st.chg_prev[21]))
      |=> st.grp_flag[2])
    else $error("masked toggle lost");

  a_unmasked_quiet: assert property ( // (R3)
    (!st.grp_flag[0] && !grp_hit[0]) |=> !st.grp_flag[0])
    else $error("group flag set without change");

  a_reserved_read: assert property ( // (R16)
    (bus_i.rd && bus_i.addr == `EPI_OFS_MASK1) |=> (rdata_o[7] == 1'b0)
      && (rdata_o[6:0] == $past(st.mask1)))
    else $error("mask read wrong");

  a_sync_order: assert property ( // (R19)
    primed ##1 (st.req_sync[1] != st.req_prev[1]) |-> st.req_prev[1] == $past(st.req_sync[1]))
    else $error("sample order broken");

  a_req0_gate: assert property ( // (R12)
    vec_req_o[0] |-> $past(global_irq_en_i && st.req_en[0]))
    else $error("request 0 without enables");

  a_req1_gate: assert property ( // (R12)
    vec_req_o[1] |-> $past(global_irq_en_i && st.req_en[1]))
    else $error("request 1 without enables");

  a_group0_gate: assert property ( // (R17)
    vec_req_o[2] |-> $past(global_irq_en_i && st.grp_en[0]))
    else $error("group 0 request without enables");

  a_group1_gate: assert property ( // (R17)
    vec_req_o[3] |-> $past(global_irq_en_i && st.grp_en[1]))
    else $error("group 1 request without enables");

  a_irq_summary: assert property ( // (R13)
    irq_o == (|vec_req_o))
    else $error("irq does not match requests");

  a_level_flag0: assert property ( // (R15)
    (st.sense[1:0] == 2'h0) |=> !st.req_flag[0])
    else $error("flag 0 set in level mode");

  a_rise_sets_flag: assert property ( // (R14)
    (st.sense[3:2] == 2'h3 && io_clk_run_i && primed
      && !st.req_prev[1] && st.req_sync[1]) |=> st.req_flag[1])
    else $error("rising edge lost");

  a_group1_toggle: assert property ( // (R2)
    (st.mask1[0] && primed && (st.chg_sync[8] != st.chg_prev[8]))
      |=> st.grp_flag[1])
    else $error("group 1 toggle lost");

  a_stopped_clock: assert property ( // (R7)
    (!io_clk_run_i && !st.req_flag[0]) |=> !st.req_flag[0])
    else $error("edge taken without io clock");

  a_wake_level: assert property ( // (R8)
    (st.req_en[0] && st.sense[1:0] == 2'h0 && primed && !st.req_sync[0]) |=> wake_o)
    else $error("level wake lost");

  a_wake_group: assert property ( // (R4)
    (grp_hit[1] && st.grp_en[1]) |=> wake_o)
    else $error("pin change wake lost");

  a_req_w1c: assert property ( // (R14)
    (bus_i.wr && bus_i.addr == `EPI_OFS_REQ_FLAGS && bus_i.wdata[0] && !edge_hit[0])
      |=> !st.req_flag[0])
    else $error("request flag not cleared");

  a_grp_w1c: assert property ( // (R18)
    (bus_i.wr && bus_i.addr == `EPI_OFS_GRP_FLAGS && bus_i.wdata[1] && !grp_hit[1])
      |=> !st.grp_flag[1])
    else $error("group flag not cleared");

  a_mask1_write: assert property ( // (R16)
    (bus_i.wr && bus_i.addr == `EPI_OFS_MASK1) |=> (st.mask1 == $past(bus_i.wdata[6:0])))
    else $error("mask write wrong");

  a_idle_read: assert property ( // (R16)
    !bus_i.rd |=> (rdata_o == `EPI_RST_REG))
    else $error("read data outside read cycle");

  a_sense_read: assert property ( // (R16)
    (bus_i.rd && bus_i.addr == `EPI_OFS_SENSE) |=> (rdata_o[7:4] == 4'h0))
    else $error("sense reserved bits set");

  a_enable_read: assert property ( // (R16)
    (bus_i.rd && bus_i.addr == `EPI_OFS_REQ_EN) |=> (rdata_o[7:2] == 6'h00))
    else $error("enable reserved bits set");

  a_group_read: assert property ( // (R16)
    (bus_i.rd && bus_i.addr == `EPI_OFS_GRP_EN) |=> (rdata_o[7:3] == 5'h00))
    else $error("group enable reserved bits set");

endmodule : epi_top

// File: verif/epi_cpu_model.sv
module epi_cpu_model
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // cpu side
  input wire logic ack_en_i,
  input wire logic [4:0] vec_req_i,
  output logic [4:0] vector_taken_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic busy;
  // ==========================================================
  // vector entry: lowest pending request, then one quiet cycle
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i || busy || !ack_en_i || vec_req_i == 5'h00)
    begin
      vector_taken_o <= 5'h00;
      busy <= 1'b0;
    end
    else
    begin
      vector_taken_o <= vec_req_i & (~vec_req_i + 5'h01);
      busy <= 1'b1;
    end
  end
endmodule : epi_cpu_model

// File: verif/tb_top.sv
module tb_top
  import epi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_i = 1'b0;
  logic rst_n, p0, p1, gie, io, ack;
  logic [23:0] chg;
  logic [7:0] rdata, d;
  logic [4:0] vec_req, taken;
  logic irq, wake;
  epi_bus_s bus;
  int errors = 0;
  int check_count = 0;
  int n0 = 0;
  int n1 = 0;
  always #4 mclk_i = ~mclk_i;
  epi_top epi_top_i (.mclk_i(mclk_i), .rst_n_i(rst_n), .bus_i(bus), .rdata_o(rdata),
    .request_pin_0_i(p0), .request_pin_1_i(p1), .change_inputs_i(chg),
    .global_irq_en_i(gie), .io_clk_run_i(io), .vector_taken_i(taken),
    .vec_req_o(vec_req), .irq_o(irq), .wake_o(wake));
  epi_cpu_model epi_cpu_model_i (.mclk_i(mclk_i), .rst_n_i(rst_n), .ack_en_i(ack),
    .vec_req_i(vec_req), .vector_taken_o(taken));
  always @(posedge mclk_i)
    if (taken[0] === 1'b1)
      n0++;
  always @(posedge mclk_i)
    if (taken[1] === 1'b1)
      n1++;
  // ==========================================================
  // bus and check tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk_i);
    bus.addr <= a;
    bus.wdata <= v;
    bus.wr <= 1'b1;
    @(posedge mclk_i);
    bus.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge mclk_i);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge mclk_i);
    bus.rd <= 1'b0;
    @(posedge mclk_i);
    v = rdata;
  endtask : rd
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic results();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results
  // ==========================================================
  // watchdog
  initial
  begin
    cyc(20000);
    errors++;
    results();
  end
  // ==========================================================
  // tests
  initial
  begin
    rst_n = 1'b0;
    bus = '0;
    p0 = 1'b1;
    p1 = 1'b1;
    chg = 24'h000000;
    gie = 1'b0;
    io = 1'b1;
    ack = 1'b0;
    cyc(10);
    rst_n <= 1'b1;
    cyc(4);
    rd(8'h69, d); chk("sense_rst", d, 8'h00);
    wr(8'h69, 8'hFF); rd(8'h69, d); chk("sense", d, 8'h0F);
    wr(8'h1D, 8'hFF); rd(8'h1D, d); chk("req_en", d, 8'h03);
    wr(8'h68, 8'hFF); rd(8'h68, d); chk("grp_en", d, 8'h07);
    rd(8'h00, d); chk("unmapped", d, 8'h00);
    for (int m = 1; m < 4; m++)
    begin
      wr(8'h69, {6'h03, m[1:0]});
      p0 <= 1'b0;
      cyc(6);
      rd(8'h1C, d); chk("fall", d, {7'h00, m != 3});
      chk("irq_off", {7'h00, irq}, 8'h00);
      wr(8'h1C, 8'h01);
      p0 <= 1'b1;
      cyc(6);
      rd(8'h1C, d); chk("rise", d, {7'h00, m != 2});
      wr(8'h1C, 8'h01);
      rd(8'h1C, d); chk("w1c", d, 8'h00);
    end
    wr(8'h69, 8'h0E);
    gie <= 1'b1;
    ack <= 1'b1;
    p1 <= 1'b0;
    p0 <= 1'b0;
    cyc(8);
    chk("vec0", n0[7:0], 8'h01);
    rd(8'h1C, d); chk("vec_clr", d, 8'h00);
    p1 <= 1'b1;
    cyc(8);
    chk("vec1", n1[7:0], 8'h01);
    ack <= 1'b0;
    wr(8'h69, 8'h0C);
    cyc(7);
    chk("level", {3'h0, vec_req}, 8'h01);
    chk("irq_on", {7'h00, irq}, 8'h01);
    rd(8'h1C, d); chk("lvl_flag", d, 8'h00);
    p0 <= 1'b1;
    cyc(6);
    chk("level_off", {3'h0, vec_req}, 8'h00);
    gie <= 1'b0;
    wr(8'h69, 8'h0E);
    io <= 1'b0;
    p0 <= 1'b0;
    cyc(6);
    io <= 1'b1;
    cyc(2);
    rd(8'h1C, d); chk("io_stop", d, 8'h00);
    wr(8'h6C, 8'h01);
    chg <= 24'h000200;
    cyc(6);
    rd(8'h1B, d); chk("masked", d, 8'h00);
    io <= 1'b0;
    chg <= 24'h000300;
    cyc(6);
    io <= 1'b1;
    rd(8'h1B, d); chk("grp1", d, 8'h02);
    chk("wake", {7'h00, wake}, 8'h01);
    chk("grp_gate", {3'h0, vec_req}, 8'h00);
    wr(8'h1B, 8'h02);
    rd(8'h1B, d); chk("grp_clr", d, 8'h00);
    wr(8'h6D, 8'h20);
    chg <= 24'h200200;
    cyc(1);
    wr(8'h1B, 8'h02);
    rd(8'h1B, d); chk("set_wins", d, 8'h06);
    results();
  end
endmodule : tb_top
